// [rtl/cfg_cmd_status.sv]
/*
 * Configuration identification, command and status registers of the
 * host controller function, with the gating of interrupt, error and
 * bus-engine enables that the command bits control.
 * Assumes the configuration decoder presents one-cycle read/write
 * strobes with an 8-bit byte offset, and the bus engine reports events
 * as one-cycle pulses on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module cfg_cmd_status
    import cfg_cmd_status_pkg::*;
#(
    parameter logic [15:0] FUNCTION_ID = FUNCTION_ID_DEFAULT
) (
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        resetn_in,
    // configuration access
    input  wire cfg_req_s    cfg_req_in,
    output logic [15:0]      cfg_rdata_out,
    output logic             cfg_rvalid_out,
    // bus engine events and requests
    input  wire hw_event_s   hw_event_in,
    input  wire logic        mem_cycle_hit_in,
    input  wire logic        io_cycle_hit_in,
    input  wire logic        special_cycle_in,
    input  wire logic        master_req_in,
    input  wire logic        master_write_in,
    input  wire logic        master_line_write_in,
    // gated outputs
    output bus_enable_s      bus_enable_out,
    output logic             mem_claim_out,
    output logic             master_go_out,
    output logic             master_use_mwi_out,
    output logic             irq_out,
    output logic             serr_drive_out,
    output logic             perr_drive_out
);

    // =====================================================================
    // access decode
    logic        wr_cmd;
    logic        wr_sts;
    logic [15:0] wr_bits;

    always_comb begin
        wr_bits = '0;
        wr_bits[7:0]  = cfg_req_in.byte_en[0] ? cfg_req_in.wdata[7:0]  : 8'h00;
        wr_bits[15:8] = cfg_req_in.byte_en[1] ? cfg_req_in.wdata[15:8] : 8'h00;
        wr_cmd = cfg_req_in.write
                 && (cfg_req_in.offset == OFS_BUS_COMMAND_CONTROL);
        wr_sts = cfg_req_in.write
                 && (cfg_req_in.offset == OFS_BUS_STATUS_FLAGS);
    end

    // =====================================================================
    // command register
    logic [15:0] cmd_r;
    logic [15:0] cmd_nxt;
    logic [15:0] cmd_be_mask;

    always_comb begin
        cmd_be_mask = {{8{cfg_req_in.byte_en[1]}}, {8{cfg_req_in.byte_en[0]}}};
        cmd_nxt = cmd_r;
        if (wr_cmd) begin
            // fixed bits never load, so they stay zero
            cmd_nxt = (cmd_r & ~(CMD_WRITE_MASK & cmd_be_mask))
                    | (wr_bits & CMD_WRITE_MASK & cmd_be_mask);
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cmd_r <= CMD_RESET;
        end else begin
            cmd_r <= cmd_nxt;
        end
    end

    // =====================================================================
    // status register
    logic [15:0] sts_r;
    logic [15:0] sts_set;
    logic [15:0] sts_clr;

    always_comb begin
        sts_set = '0;
        sts_set[STS_PARITY_FAULT] = hw_event_in.addr_parity
                                  | hw_event_in.data_parity;
        sts_set[STS_SYSTEM_ERROR] = hw_event_in.addr_parity
                                  & cmd_r[CMD_SYSTEM_ERROR];
        sts_set[STS_MASTER_ABORT_RX] = hw_event_in.master_abort_rx;
        sts_set[STS_TARGET_ABORT_RX] = hw_event_in.target_abort_rx;
        sts_set[STS_TARGET_ABORT_TX] = hw_event_in.target_abort_tx;
        sts_set[STS_DATA_PARITY] = hw_event_in.perr_seen_as_master
                                 & cmd_r[CMD_PARITY_RESPONSE];
        sts_clr = wr_sts ? (wr_bits & STS_CLEAR_MASK) : 16'h0000;
    end

    // set wins over a simultaneous clear
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sts_r <= STS_RESET;
        end else begin
            sts_r <= ((sts_r & ~sts_clr) | sts_set) & STS_CLEAR_MASK;
        end
    end

    // live interrupt level, unaffected by the mask
    logic int_pend_r;

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            int_pend_r <= 1'b0;
        end else begin
            int_pend_r <= hw_event_in.int_condition;
        end
    end

    // =====================================================================
    // read path
    logic [15:0] sts_view;
    logic [15:0] rd_mux;

    always_comb begin
        // fixed timing and capability bits overlay clearable flags
        sts_view = sts_r | STS_FIXED;
        sts_view[STS_INT_PENDING] = int_pend_r;
        unique case (cfg_req_in.offset)
            OFS_FUNCTION_IDENTIFIER: rd_mux = FUNCTION_ID;
            OFS_BUS_COMMAND_CONTROL: rd_mux = cmd_r;
            OFS_BUS_STATUS_FLAGS:    rd_mux = sts_view;
            default:                 rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg_rdata_out  <= 16'h0000;
            cfg_rvalid_out <= 1'b0;
        end else begin
            cfg_rvalid_out <= cfg_req_in.read;
            cfg_rdata_out  <= cfg_req_in.read ? rd_mux : 16'h0000;
        end
    end

    // =====================================================================
    // gated bus-engine controls, registered for clean outputs
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            bus_enable_out     <= '0;
            mem_claim_out      <= 1'b0;
            master_go_out      <= 1'b0;
            master_use_mwi_out <= 1'b0;
        end else begin
            bus_enable_out.memory_space_enable <= cmd_r[CMD_MEMORY_SPACE];
            bus_enable_out.bus_initiator_enable <= cmd_r[CMD_BUS_INITIATOR];
            bus_enable_out.write_invalidate_enable
                <= cmd_r[CMD_WRITE_INVALIDATE];
            bus_enable_out.parity_error_response_enable
                <= cmd_r[CMD_PARITY_RESPONSE];
            bus_enable_out.system_error_driver_enable
                <= cmd_r[CMD_SYSTEM_ERROR];
            // hardwired off: never mastered, snooped, decoded
            bus_enable_out.fast_b2b_enable      <= cmd_r[CMD_FAST_B2B];
            bus_enable_out.special_cycle_enable <= cmd_r[CMD_SPECIAL_CYCLE];
            bus_enable_out.port_space_enable    <= cmd_r[CMD_PORT_SPACE];
            // io and special cycles never claimed
            mem_claim_out <= mem_cycle_hit_in & ~io_cycle_hit_in
                           & ~special_cycle_in
                           & cmd_r[CMD_MEMORY_SPACE];
            master_go_out <= master_req_in
                           & cmd_r[CMD_BUS_INITIATOR];
            // line writes use write invalidate only while CMD_WRITE_INVALIDATE is set, else plain memory write
            master_use_mwi_out <= master_req_in & master_write_in
                                & master_line_write_in
                                & cmd_r[CMD_BUS_INITIATOR]
                                & cmd_r[CMD_WRITE_INVALIDATE];
        end
    end

    // =====================================================================
    // interrupt and error pin drivers
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_out        <= 1'b0;
            serr_drive_out <= 1'b0;
            perr_drive_out <= 1'b0;
        end else begin
            irq_out <= hw_event_in.int_condition
                     & ~cmd_r[CMD_INT_MASK];
            serr_drive_out <= hw_event_in.addr_parity
                            & cmd_r[CMD_SYSTEM_ERROR];
            perr_drive_out <= hw_event_in.data_parity
                            & cmd_r[CMD_PARITY_RESPONSE];
        end
    end

endmodule

`default_nettype wire

// [rtl/cfg_cmd_status_pkg.sv]
/*
 * Package for the configuration command/status register block: offsets,
 * field positions, masks, reset values and the carrier structs.
 * Assumes a 16-bit view of configuration space at the printed offsets.
 */
package cfg_cmd_status_pkg;

    // =====================================================================
    // offsets
    localparam logic [7:0] OFS_FUNCTION_IDENTIFIER = 8'h02;
    localparam logic [7:0] OFS_BUS_COMMAND_CONTROL = 8'h04;
    localparam logic [7:0] OFS_BUS_STATUS_FLAGS    = 8'h06;

    // =====================================================================
    // command field positions
    localparam int CMD_PORT_SPACE       = 0;
    localparam int CMD_MEMORY_SPACE     = 1;
    localparam int CMD_BUS_INITIATOR    = 2;
    localparam int CMD_SPECIAL_CYCLE    = 3;
    localparam int CMD_WRITE_INVALIDATE = 4;
    localparam int CMD_PALETTE_SNOOP    = 5;
    localparam int CMD_PARITY_RESPONSE  = 6;
    localparam int CMD_SYSTEM_ERROR     = 8;
    localparam int CMD_FAST_B2B         = 9;
    localparam int CMD_INT_MASK         = 10;

    // writable command bits: 10, 8, 6, 4, 2, 1
    localparam logic [15:0] CMD_WRITE_MASK = 16'h0556;
    localparam logic [15:0] CMD_RESET      = 16'h0000;

    // =====================================================================
    // status field positions
    localparam int STS_INT_PENDING     = 3;
    localparam int STS_CAP_LIST        = 4;
    localparam int STS_DATA_PARITY     = 8;
    localparam int STS_TARGET_ABORT_TX = 11;
    localparam int STS_TARGET_ABORT_RX = 12;
    localparam int STS_MASTER_ABORT_RX = 13;
    localparam int STS_SYSTEM_ERROR    = 14;
    localparam int STS_PARITY_FAULT    = 15;

    // fixed part: decode timing 01b in bits 10:9, capability list bit 4
    localparam logic [15:0] STS_FIXED      = 16'h0210;
    localparam logic [15:0] STS_CLEAR_MASK = 16'hF900;
    localparam logic [15:0] STS_RESET      = 16'h0000;

    // arbitrary neutral identification value
    localparam logic [15:0] FUNCTION_ID_DEFAULT = 16'h0001;

    // =====================================================================
    // configuration access
    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  offset;
        logic [1:0]  byte_en;
        logic [15:0] wdata;
    } cfg_req_s;

    // hardware status events, one-cycle pulses except the int_condition level
    typedef struct packed {
        logic addr_parity;
        logic data_parity;
        logic perr_seen_as_master;
        logic master_abort_rx;
        logic target_abort_rx;
        logic target_abort_tx;
        logic int_condition;
    } hw_event_s;

    // enables handed to the bus engine
    typedef struct packed {
        logic memory_space_enable;
        logic bus_initiator_enable;
        logic write_invalidate_enable;
        logic parity_error_response_enable;
        logic system_error_driver_enable;
        logic fast_b2b_enable;
        logic special_cycle_enable;
        logic port_space_enable;
    } bus_enable_s;

endpackage

// [testbench/cfg_cmd_status_sva.sv]
/* Checker for the command/status block: fixed bits and output gating.
   Assumes it is bound into every cfg_cmd_status instance. */
`timescale 1ns/1ps
`default_nettype none
module cfg_cmd_status_sva
    import cfg_cmd_status_pkg::*;
#(
    parameter logic [15:0] FUNCTION_ID = FUNCTION_ID_DEFAULT
) (
    // clock, reset, configuration
    input wire logic        clk_sys_in,
    input wire logic        resetn_in,
    input wire cfg_req_s    cfg_req_in,
    input wire logic [15:0] cfg_rdata_out,
    input wire logic        cfg_rvalid_out,
    // bus engine side
    input wire hw_event_s   hw_event_in,
    input wire logic        mem_cycle_hit_in,
    input wire logic        io_cycle_hit_in,
    input wire logic        special_cycle_in,
    input wire logic        master_req_in,
    input wire logic        master_write_in,
    input wire logic        master_line_write_in,
    input wire bus_enable_s bus_enable_out,
    input wire logic        mem_claim_out,
    input wire logic        master_go_out,
    input wire logic        master_use_mwi_out,
    input wire logic        irq_out,
    input wire logic        serr_drive_out,
    input wire logic        perr_drive_out
);
    // ==================================================================
    // properties
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    sequence s_rd(logic [7:0] o);
        cfg_req_in.read && cfg_req_in.offset == o;
    endsequence
    a_id_fixed:
    assert property (s_rd(8'h02) |=> cfg_rvalid_out
        && cfg_rdata_out == FUNCTION_ID) else $error("id read wrong");
    a_cmd_fixed_zero:
    assert property (s_rd(8'h04) |=> (cfg_rdata_out & ~CMD_WRITE_MASK)
        == 16'h0000) else $error("fixed command bit set");
    a_sts_fixed_bits:
    assert property (s_rd(8'h06) |=> cfg_rdata_out[10:9] == 2'b01
        && cfg_rdata_out[7:4] == 4'h1 && cfg_rdata_out[2:0] == 3'h0
        && cfg_rdata_out[3] == $past(hw_event_in.int_condition, 2))
        else $error("status fixed bits wrong");
    a_no_ext_modes:
    assert property ({bus_enable_out.fast_b2b_enable,
        bus_enable_out.special_cycle_enable,
        bus_enable_out.port_space_enable} == 3'h0)
        else $error("unsupported mode enabled");
    a_serr_gate:
    assert property (serr_drive_out == ($past(hw_event_in.addr_parity)
        && bus_enable_out.system_error_driver_enable))
        else $error("serr gating wrong");
    a_perr_gate:
    assert property (perr_drive_out == ($past(hw_event_in.data_parity)
        && bus_enable_out.parity_error_response_enable))
        else $error("perr gating wrong");
    a_master_gate:
    assert property (master_go_out == ($past(master_req_in)
        && bus_enable_out.bus_initiator_enable))
        else $error("master gating wrong");
    a_mwi_gate:
    assert property (master_use_mwi_out |-> master_go_out
        && $past(master_write_in && master_line_write_in)
        && bus_enable_out.write_invalidate_enable)
        else $error("write invalidate gating wrong");
    a_mem_claim_gate:
    assert property (mem_claim_out == ($past(mem_cycle_hit_in
        && !io_cycle_hit_in && !special_cycle_in)
        && bus_enable_out.memory_space_enable))
        else $error("memory claim gating wrong");
    a_irq_cause:
    assert property (irq_out |-> $past(hw_event_in.int_condition))
        else $error("irq without condition");
endmodule
bind cfg_cmd_status cfg_cmd_status_sva #(.FUNCTION_ID(FUNCTION_ID)) u_sva (
    .clk_sys_in, .resetn_in, .cfg_req_in, .cfg_rdata_out, .cfg_rvalid_out,
    .hw_event_in, .mem_cycle_hit_in, .io_cycle_hit_in, .special_cycle_in,
    .master_req_in, .master_write_in, .master_line_write_in,
    .bus_enable_out, .mem_claim_out, .master_go_out, .master_use_mwi_out,
    .irq_out, .serr_drive_out, .perr_drive_out);
`default_nettype wire

// [testbench/cfg_host_model.sv]
/* Host-side model issuing configuration reads and writes.
   Assumes the block's clock and a one-cycle-later read answer. */
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model
    import cfg_cmd_status_pkg::*;
(
    // clock and answer
    input  wire logic        clk_in,
    input  wire logic [15:0] rdata_in,
    input  wire logic        rvalid_in,
    // request
    output var  cfg_req_s    req_out
);
    // ==================================================================
    // access tasks
    initial req_out = '0;
    // released lines show the inverse, never a stale copy
    task automatic wr(input logic [7:0] o, input logic [1:0] be,
                      input logic [15:0] d);
        @(posedge clk_in);
        req_out <= '{1'b0, 1'b1, o, be, d};
        @(posedge clk_in);
        req_out <= '{1'b0, 1'b0, ~o, ~be, ~d};
    endtask
    task automatic rd(input logic [7:0] o, output logic [15:0] d);
        @(posedge clk_in);
        req_out <= '{1'b1, 1'b0, o, 2'b00, 16'h0000};
        @(posedge clk_in);
        req_out <= '{1'b0, 1'b0, ~o, 2'b11, 16'hFFFF};
        #1;
        d = rvalid_in ? rdata_in : 16'hXXXX;
    endtask
endmodule
`default_nettype wire

// [testbench/pci_cfg_command_status_tb.sv]
/* Self-checking bench for the command/status block.
   Assumes the checker is compiled alongside and bound in. */
`timescale 1ns/1ps
`default_nettype none
module pci_cfg_command_status_tb
    import cfg_cmd_status_pkg::*;
;
    logic        clk_sys_in = 1'b0;
    logic        resetn_in  = 1'b0;
    cfg_req_s    req;
    logic [15:0] rdata;
    logic [15:0] v;
    logic        rvalid, claim, go, mwi, irq, serr, perr;
    hw_event_s   ev = '0;
    logic [5:0]  lv = '0;
    int          errors = 0;
    int          check_count = 0;

    initial forever #2.5 clk_sys_in = ~clk_sys_in;

    cfg_host_model host (.clk_in(clk_sys_in), .rdata_in(rdata),
        .rvalid_in(rvalid), .req_out(req));
    cfg_cmd_status dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .cfg_req_in(req), .cfg_rdata_out(rdata), .cfg_rvalid_out(rvalid),
        .hw_event_in(ev), .mem_cycle_hit_in(lv[5]),
        .io_cycle_hit_in(lv[4]), .special_cycle_in(lv[3]),
        .master_req_in(lv[2]), .master_write_in(lv[1]),
        .master_line_write_in(lv[0]), .bus_enable_out(),
        .mem_claim_out(claim), .master_go_out(go),
        .master_use_mwi_out(mwi), .irq_out(irq),
        .serr_drive_out(serr), .perr_drive_out(perr));

    // ==================================================================
    // helpers
    task automatic chk(input string n, input logic [15:0] s, e);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic rchk(input logic [7:0] o, input logic [15:0] e);
        host.rd(o, v);
        chk($sformatf("reg %h", o), v, e);
    endtask
    // one-cycle event pulse; the interrupt level is kept as it is
    task automatic pulse(input logic [6:0] p);
        @(posedge clk_sys_in);
        ev <= p | (ev & 7'h01);
        @(posedge clk_sys_in);
        ev <= ev & 7'h01;
        #1;
    endtask
    task automatic outs(input logic [15:0] e);
        chk("outs", 16'({serr, perr, claim, go, mwi, irq}), e);
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ==================================================================
    // tests
    initial begin
        repeat (5) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        rchk(8'h04, 16'h0000);
        rchk(8'h06, 16'h0210);
        host.wr(8'h02, 2'b11, 16'hFFFF);
        rchk(8'h02, FUNCTION_ID_DEFAULT);
        rchk(8'h08, 16'h0000);
        host.wr(8'h04, 2'b11, 16'hFFFF);
        rchk(8'h04, 16'h0556);
        // memory space enabled above, before any memory hit
        @(posedge clk_sys_in);
        lv <= 6'h27;
        ev.int_condition <= 1'b1;
        pulse(7'h7E);
        // mask bit 10 was set by the all-ones write, so no interrupt
        outs(16'h003E);
        rchk(8'h06, 16'hFB18);
        host.wr(8'h06, 2'b01, 16'hF900);
        rchk(8'h06, 16'hFB18);
        host.wr(8'h06, 2'b11, 16'h0900);
        rchk(8'h06, 16'hF218);
        @(posedge clk_sys_in);
        ev.int_condition <= 1'b0;
        fork
            host.wr(8'h06, 2'b11, 16'hF900);
            pulse(7'h40);
        join
        rchk(8'h06, 16'hC210);
        host.wr(8'h06, 2'b11, 16'hFFFF);
        host.wr(8'h04, 2'b11, 16'h0400);
        @(posedge clk_sys_in);
        ev.int_condition <= 1'b1;
        pulse(7'h70);
        outs(16'h0000);
        rchk(8'h06, 16'h8218);
        host.wr(8'h04, 2'b11, 16'h0006);
        repeat (2) @(posedge clk_sys_in);
        #1;
        // mask now clear and the condition still high: interrupt shows
        outs(16'h000D);
        give_verdict();
    end

    initial begin
        #20000;
        errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
